// ==== src/usb_irq_defines.svh ====
// Register offsets, field positions and reset values of the interrupt event block.
// Assumes inclusion by bare name from any design file.
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH
`define OFF_COMMAND_STATUS 12'h008
`define OFF_EVENT_STATUS 12'h00c
`define OFF_MASK_SET 12'h010
`define OFF_EVENT_RAISE 12'h040
`define OFF_HALT_STATE 12'h044
`define BIT_MIE 31
`define BIT_OC 30
`define BIT_ROOT_HUB_CHANGE_FLAG 6
`define BIT_FNO 5
`define BIT_UE 4
`define BIT_RD 3
`define BIT_SF 2
`define BIT_WDH 1
`define BIT_SO 0
`define BIT_OCR 3
`define BIT_SOC_LO 16
`define STATUS_IMPL_MASK 32'h4000007f
`define MASK_IMPL_MASK 32'hc000007f
`define RESET_WORD 32'h00000000
`endif

// ==== src/usb_irq_pkg.sv ====
// Types shared by the interrupt event block.
// Assumes the defines header is compiled alongside.
package usb_irq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [1:0] overrun_count_t;
endpackage

// ==== src/edge_sync.sv ====
// Two-flop synchroniser with rising-edge pulse, for events arriving from pins.
// Assumes one clock pclk and asynchronous active-low reset.
`timescale 1ns/10ps
module edge_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw level and its rising edge
  input wire logic raw,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;
  sync_s st_q, st_d;
  // Next state: first flop only feeds the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  // Register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign rise = st_q.s2 & ~st_q.s3;
endmodule

// ==== src/apb_regslot.sv ====
// APB slave decode: ready in the access phase, one wait-free answer.
// Assumes an APB3 master on pclk; registers live in the caller.
`timescale 1ns/10ps
module apb_regslot (
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // Decoded strobes
  output logic wr_stb,
  output logic rd_stb,
  output logic [11:0] word_addr
);
  // Transfer completes in its first access cycle
  assign wr_stb = psel & penable & pwrite;
  assign rd_stb = psel & ~penable & ~pwrite;
  assign word_addr = {paddr[11:2], 2'b00};
endmodule

// ==== src/usb_host_interrupt_status_enable.sv ====
// Interrupt event status and enable logic of a USB open host controller function.
// Assumes APB master on pclk, events from controller logic or pins as listed.
`timescale 1ns/10ps
`include "usb_irq_defines.svh"
module usb_host_interrupt_status_enable #(
  // Build with a management interrupt pin
  parameter bit HAS_SMI_PIN = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the controller logic, same clock, one-cycle pulses
  input wire logic root_hub_change_evt,
  input wire logic frame_msb_evt,
  input wire logic frame_copy_done_evt,
  input wire logic host_bus_fail_evt,
  input wire logic sof_token_evt,
  input wire logic done_head_written_evt,
  input wire logic schedule_overrun_evt,
  input wire logic sw_resume_cmd,
  // Resume line from the USB side, asynchronous level
  input wire logic resume_signal_pin,
  // Controller outputs
  output logic host_irq,
  output logic system_mgmt_interrupt_pin,
  output logic done_head_write_allow,
  output logic processing_halt,
  output usb_irq_pkg::overrun_count_t overrun_count
);
  import usb_irq_pkg::*;

  // All block state
  typedef struct packed {
    word_t status;
    word_t mask;
    logic ownership_change_request;
    overrun_count_t soc;
    logic halt;
    logic resume_prev_cmd;
    word_t rdata;
    logic irq;
    logic smi;
    logic wb_allow;
  } state_s;
  state_s st_q, st_d;

  // Decoded bus strobes
  logic wr_stb;
  logic rd_stb;
  logic [11:0] waddr;
  logic resume_rise;

  // Bus decode
  apb_regslot u_slot (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .word_addr(waddr)
  );

  // Resume line crosses in through two flops
  edge_sync u_resume (
    .pclk(pclk),
    .presetn(presetn),
    .raw(resume_signal_pin),
    .rise(resume_rise)
  );

  // Write-one-to-clear with set winning over clear
  function automatic word_t w1c(input word_t cur, input word_t set, input word_t clr);
    w1c = (cur & ~clr) | set;
  endfunction

  // Read mux for a given word address
  function automatic word_t read_word(input logic [11:0] a, input state_s s);
    unique case (a)
      `OFF_COMMAND_STATUS: read_word = {14'h0000, s.soc, 12'h000, s.ownership_change_request, 3'h0};
      `OFF_EVENT_STATUS: read_word = s.status;
      `OFF_MASK_SET: read_word = s.mask;
      `OFF_HALT_STATE: read_word = {31'h00000000, s.halt};
      default: read_word = `RESET_WORD;
    endcase
  endfunction

  word_t set_v;
  word_t clr_v;
  word_t irq_v;

  // Next-state logic
  always_comb begin
    st_d = st_q;
    set_v = `RESET_WORD;
    clr_v = `RESET_WORD;
    // Ownership request: software sets, change clears it
    if (wr_stb && waddr == `OFF_COMMAND_STATUS && pwdata[`BIT_OCR]) begin
      st_d.ownership_change_request = 1'b1;
    end
    // Ownership change flag follows the request
    if (st_q.ownership_change_request && HAS_SMI_PIN) begin
      set_v[`BIT_OC] = 1'b1;
      st_d.ownership_change_request = 1'b0;
    end
    // Event capture
    set_v[`BIT_ROOT_HUB_CHANGE_FLAG] = root_hub_change_evt;
    set_v[`BIT_FNO] = frame_msb_evt | frame_copy_done_evt;
    set_v[`BIT_UE] = host_bus_fail_evt;
    set_v[`BIT_RD] = resume_rise & ~sw_resume_cmd;
    set_v[`BIT_SF] = sof_token_evt;
    set_v[`BIT_WDH] = done_head_written_evt;
    set_v[`BIT_SO] = schedule_overrun_evt;
    // Overrun counter wraps naturally, counts even with flag set
    if (schedule_overrun_evt) begin
      st_d.soc = overrun_count_t'(st_q.soc + 2'd1);
    end
    // Software write-one clears status bits only
    if (wr_stb && waddr == `OFF_EVENT_STATUS) begin
      clr_v = pwdata & `STATUS_IMPL_MASK;
    end
    // Test-free raise path is absent: writes never set status
    st_d.status = w1c(st_q.status, set_v, clr_v) & `STATUS_IMPL_MASK;
    if (!HAS_SMI_PIN) begin
      st_d.status[`BIT_OC] = 1'b0;
    end
    // Enable register is set-only
    if (wr_stb && waddr == `OFF_MASK_SET) begin
      st_d.mask = st_q.mask | (pwdata & `MASK_IMPL_MASK);
    end
    // Halt latches on error, released by software write to halt register
    if (host_bus_fail_evt) begin
      st_d.halt = 1'b1;
    end else if (wr_stb && waddr == `OFF_HALT_STATE && pwdata[0]) begin
      st_d.halt = 1'b0;
    end
    // Interrupt level registered from the next flags and enables, so it moves on the same edge as they do
    irq_v = st_d.status & st_d.mask;
    irq_v[`BIT_OC] = 1'b0;
    st_d.irq = st_d.mask[`BIT_MIE] && (|irq_v);
    // Ownership change goes to the management pin at once
    st_d.smi = st_d.status[`BIT_OC] & st_d.mask[`BIT_OC];
    // Write-back held off while its flag stands
    st_d.wb_allow = ~st_d.status[`BIT_WDH];
    // Read data captured in the setup cycle
    if (rd_stb) begin
      st_d.rdata = read_word(waddr, st_q);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.wb_allow <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops; pready and pslverr tied off
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign host_irq = st_q.irq;
  assign system_mgmt_interrupt_pin = st_q.smi;
  assign done_head_write_allow = st_q.wb_allow;
  assign processing_halt = st_q.halt;
  assign overrun_count = st_q.soc;

  // Assertions
  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn)
      host_irq |-> st_q.mask[`BIT_MIE] && |(st_q.status & st_q.mask & 32'h0000007f);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");
  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st_q.status[`BIT_SF] && !(wr_stb && waddr == `OFF_EVENT_STATUS && pwdata[`BIT_SF]))
      |=> st_q.status[`BIT_SF];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
  property p_sof_set;
    @(posedge pclk) disable iff (!presetn) sof_token_evt |=> st_q.status[`BIT_SF];
  endproperty
  a_sof_set: assert property (p_sof_set) else $error("sof flag not set");
  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr_stb && waddr == `OFF_EVENT_STATUS && pwdata[`BIT_ROOT_HUB_CHANGE_FLAG] && !root_hub_change_evt)
      |=> !st_q.status[`BIT_ROOT_HUB_CHANGE_FLAG];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_mask_set_only;
    @(posedge pclk) disable iff (!presetn) st_q.mask[`BIT_SO] |=> st_q.mask[`BIT_SO];
  endproperty
  a_mask_set_only: assert property (p_mask_set_only) else $error("enable dropped");
  property p_soc_inc;
    @(posedge pclk) disable iff (!presetn)
      schedule_overrun_evt |=> overrun_count == 2'($past(overrun_count) + 2'd1);
  endproperty
  a_soc_inc: assert property (p_soc_inc) else $error("overrun count off");
  property p_halt;
    @(posedge pclk) disable iff (!presetn) host_bus_fail_evt |=> processing_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt after error");
  sequence s_ocr_req;
    wr_stb && waddr == `OFF_COMMAND_STATUS && pwdata[`BIT_OCR] && st_q.mask[`BIT_OC];
  endsequence
  property p_smi;
    @(posedge pclk) disable iff (!presetn)
      s_ocr_req |-> ##[1:3] (system_mgmt_interrupt_pin || !HAS_SMI_PIN);
  endproperty
  a_smi: assert property (p_smi) else $error("smi late");
  // Allow is registered from the next flag value, so both move on one edge
  property p_wb_hold;
    @(posedge pclk) disable iff (!presetn) st_q.status[`BIT_WDH] |-> !done_head_write_allow;
  endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("write-back not held");
  // Root hub change pulse lands in its flag
  property p_root_hub_change_flag_set;
    @(posedge pclk) disable iff (!presetn)
      root_hub_change_evt |=> st_q.status[`BIT_ROOT_HUB_CHANGE_FLAG];
  endproperty
  a_root_hub_change_flag_set: assert property (p_root_hub_change_flag_set) else $error("root hub flag not set");
  // Either frame source lands in the overflow flag
  property p_fno_set;
    @(posedge pclk) disable iff (!presetn)
      (frame_msb_evt || frame_copy_done_evt) |=> st_q.status[`BIT_FNO];
  endproperty
  a_fno_set: assert property (p_fno_set) else $error("overflow flag not set");
  // Host bus failure lands in the error flag
  property p_ue_set;
    @(posedge pclk) disable iff (!presetn)
      host_bus_fail_evt |=> st_q.status[`BIT_UE];
  endproperty
  a_ue_set: assert property (p_ue_set) else $error("error flag not set");
  // Done head write-back lands in its flag
  property p_wdh_set;
    @(posedge pclk) disable iff (!presetn)
      done_head_written_evt |=> st_q.status[`BIT_WDH];
  endproperty
  a_wdh_set: assert property (p_wdh_set) else $error("write-back flag not set");
  // Overrun pulse lands in its flag
  property p_so_set;
    @(posedge pclk) disable iff (!presetn)
      schedule_overrun_evt |=> st_q.status[`BIT_SO];
  endproperty
  a_so_set: assert property (p_so_set) else $error("overrun flag not set");
  // Software-commanded resume never raises the resume flag
  property p_rd_sw;
    @(posedge pclk) disable iff (!presetn)
      (sw_resume_cmd && !st_q.status[`BIT_RD]) |=> !st_q.status[`BIT_RD];
  endproperty
  a_rd_sw: assert property (p_rd_sw) else $error("resume flag set by software");
  // A status write without an event cannot raise a clear flag
  property p_no_sw_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_stb && waddr == `OFF_EVENT_STATUS && !root_hub_change_evt && !st_q.status[`BIT_ROOT_HUB_CHANGE_FLAG])
      |=> !st_q.status[`BIT_ROOT_HUB_CHANGE_FLAG];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("write set a flag");
  // Master enable clear and not being set keeps the request low
  property p_mie_gate;
    @(posedge pclk) disable iff (!presetn)
      (!st_q.mask[`BIT_MIE] && !(wr_stb && waddr == `OFF_MASK_SET && pwdata[`BIT_MIE]))
      |=> !host_irq;
  endproperty
  a_mie_gate: assert property (p_mie_gate) else $error("irq without master enable");
  // Request stands as long as an enabled flag in bits 6:0 stands
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (st_q.mask[`BIT_MIE] && |(st_q.status & st_q.mask & 32'h0000007f)) |-> host_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level dropped");
  // Without the management pin the ownership flag never shows
  property p_oc_zero;
    @(posedge pclk) disable iff (!presetn)
      !HAS_SMI_PIN |-> !st_q.status[`BIT_OC];
  endproperty
  a_oc_zero: assert property (p_oc_zero) else $error("ownership flag without pin");
  // Count moves only on an overrun
  property p_soc_hold;
    @(posedge pclk) disable iff (!presetn)
      !schedule_overrun_evt |=> $stable(overrun_count);
  endproperty
  a_soc_hold: assert property (p_soc_hold) else $error("overrun count drifted");
  // Enable register read returns its contents at setup time
  property p_enable_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_stb && waddr == `OFF_MASK_SET) |=> prdata == $past(st_q.mask);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read wrong");
  // Management pin only with flag and its enable
  property p_smi_cause;
    @(posedge pclk) disable iff (!presetn)
      system_mgmt_interrupt_pin |-> st_q.status[`BIT_OC] && st_q.mask[`BIT_OC];
  endproperty
  a_smi_cause: assert property (p_smi_cause) else $error("smi without cause");
  // Write-back allowed again once its flag is gone
  property p_wb_release;
    @(posedge pclk) disable iff (!presetn)
      !st_q.status[`BIT_WDH] |-> done_head_write_allow;
  endproperty
  a_wb_release: assert property (p_wb_release) else $error("write-back stuck");
endmodule

// ==== testbench/event_source.sv ====
// Model of the controller logic and USB device that raise events.
// Assumes the bench sets request bits just after pclk edges.
`timescale 1ns/10ps
module event_source (
  // Requests from the bench
  input wire logic [6:0] fire,
  input wire logic resume_req,
  // Lines toward the block
  output logic [6:0] evt,
  output logic resume_pin
);
  // One request bit held one cycle gives one event pulse
  assign evt = fire;
  // Device resume level; async to the block, which must sync it
  assign resume_pin = resume_req;
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the interrupt event block, driven over APB.
// Assumes design files and the event source model are compiled first.
`timescale 1ns/10ps
`include "usb_irq_defines.svh"
module testbench;
  import usb_irq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  word_t pwdata = 32'h0, prdata, acc;
  logic pready, pslverr, irq, smi, allow, halt, pin, sw_res = 1'b0, res_req = 1'b0;
  logic [6:0] fire = 7'h00, evt;
  overrun_count_t ocnt;
  word_t exp_q[$]; // Expected read data, oldest first
  int fail_count = 0, comparisons = 0;
  int unsigned seed = 99;
  event_source partner (.fire(fire), .resume_req(res_req), .evt(evt), .resume_pin(pin));
  usb_host_interrupt_status_enable dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .root_hub_change_evt(evt[6]),
    .frame_msb_evt(evt[5]), .frame_copy_done_evt(evt[3]), .host_bus_fail_evt(evt[4]),
    .sof_token_evt(evt[2]), .done_head_written_evt(evt[1]),
    .schedule_overrun_evt(evt[0]), .sw_resume_cmd(sw_res), .resume_signal_pin(pin),
    .host_irq(irq), .system_mgmt_interrupt_pin(smi), .done_head_write_allow(allow),
    .processing_halt(halt), .overrun_count(ocnt));
  // Free-running bus clock, 50 ns period
  always #25 pclk = ~pclk;
  // Xorshift source for write data
  function automatic word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(word_t seen, word_t want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Monitor: a read completes at the access edge with pready high
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end
  // One APB transfer; request held until pready is seen high
  task automatic apb(logic wr, logic [11:0] a, word_t d, word_t e);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        print_verdict();
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Let c edges pass, then sample on the settled falling edge
  task automatic settle(int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pulse(logic [6:0] m);
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= 7'h00;
  endtask
  task automatic resume();
    @(posedge pclk);
    res_req <= 1'b1;
    settle(5);
    @(posedge pclk);
    res_req <= 1'b0;
    settle(4);
  endtask
  initial begin
    acc = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_EVENT_STATUS, 32'h0, `RESET_WORD);
    apb(1'b0, `OFF_MASK_SET, 32'h0, `RESET_WORD);
    apb(1'b0, `OFF_EVENT_RAISE, 32'h0, 32'h0);
    settle(1);
    check({28'h0, irq, smi, allow, halt}, 32'h2);
    // Software-commanded resume must not flag
    @(posedge pclk);
    sw_res <= 1'b1;
    resume();
    @(posedge pclk);
    sw_res <= 1'b0;
    apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h0);
    // Random writes never set a flag; reserved bits kept zero
    repeat (4) apb(1'b1, `OFF_EVENT_STATUS, xs() & `STATUS_IMPL_MASK, 32'h0);
    apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h0);
    // Each event flag in bits 6:0 in turn, with gating and clearing
    for (int i = 0; i < 7; i++) begin
      if (i == 3) resume();
      else pulse(7'(1 << i));
      apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h1 << i);
      settle(1);
      check({31'h0, irq}, 32'h0);
      if (i == 1) check({31'h0, allow}, 32'h0);
      if (i == 4) check({31'h0, halt}, 32'h1);
      apb(1'b1, `OFF_MASK_SET, 32'h1 << i, 32'h0);
      settle(1);
      check({31'h0, irq}, (i > 0) ? 32'h1 : 32'h0);
      apb(1'b1, `OFF_MASK_SET, 32'h80000000, 32'h0);
      acc = acc | (32'h1 << i) | 32'h80000000;
      apb(1'b0, `OFF_MASK_SET, 32'h0, acc);
      settle(1);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `OFF_EVENT_STATUS, ~(32'h1 << i) & `STATUS_IMPL_MASK, 32'h0);
      apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h1 << i);
      if (i == 4) apb(1'b1, `OFF_HALT_STATE, 32'h1, 32'h0);
      apb(1'b1, `OFF_EVENT_STATUS, 32'h1 << i, 32'h0);
      apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h0);
      settle(1);
      check({29'h0, irq, allow, halt}, 32'h2);
    end
    // Overrun count wraps and counts with the flag already set
    repeat (4) pulse(7'h01);
    settle(1);
    check({30'h0, ocnt}, 32'h1);
    apb(1'b0, `OFF_COMMAND_STATUS, 32'h0, 32'h00010000);
    apb(1'b1, `OFF_EVENT_STATUS, 32'h1, 32'h0);
    // Frame copy update also raises the overflow flag
    pulse(7'h08);
    apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h20);
    apb(1'b1, `OFF_EVENT_STATUS, 32'h20, 32'h0);
    // Ownership change request raises the management interrupt only
    apb(1'b1, `OFF_MASK_SET, 32'h40000000, 32'h0);
    apb(1'b1, `OFF_COMMAND_STATUS, 32'h8, 32'h0);
    settle(2);
    check({30'h0, smi, irq}, 32'h2);
    apb(1'b0, `OFF_EVENT_STATUS, 32'h0, 32'h40000000);
    apb(1'b1, `OFF_EVENT_STATUS, 32'h40000000, 32'h0);
    settle(1);
    check({31'h0, smi}, 32'h0);
    print_verdict();
  end
endmodule
